// ==== src/tfs_pkg.sv ====
package tfs_pkg;
  localparam int CLK_NS = 50;
  localparam int CW = 24;
  localparam int DIAG_US = 1000;
  localparam int DIAG_CYC = (DIAG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CLOSE_MS = 100;
  localparam int CLOSE_CYC = (CLOSE_MS * 1000000) / CLK_NS;
  localparam int BUS_MS = 500;
  localparam int BUS_CYC = (BUS_MS * 1000000) / CLK_NS;
  localparam int BRK_US = 10;
  localparam int BRK_CYC = (BRK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BRK_CNT = 8'(BRK_CYC);
  localparam logic [16:0] ACC_OFS_MV = 17'h003e8;
  localparam logic [7:0] T_DERATE_C = 8'h4b;
  localparam logic [7:0] T_ZERO_C = 8'h64;
  localparam logic [7:0] LIM_FULL = 8'hfa;
  localparam logic [7:0] LIM_HALF = 8'h7d;
  localparam logic [7:0] LIM_STEP = 8'h0a;
  localparam logic [6:0] BATT_LOW_PCT = 7'h0a;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ACC_MIN = 8'h04;
  localparam logic [7:0] A_PRANGE = 8'h08;
  localparam logic [7:0] A_CUTOFF = 8'h0c;
  localparam logic [7:0] A_SRANGE = 8'h10;
  localparam logic [7:0] A_FAULT = 8'h14;
  localparam logic [7:0] A_WARN = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] ACC_MIN_RST = 16'h01f4;
  localparam logic [31:0] PRANGE_RST = 32'h1194_00c8;
  localparam logic [7:0] CUTOFF_RST = 8'h78;
  localparam logic [31:0] SRANGE_RST = 32'h96_00_96_00;
  localparam int CB_BUS = 0;
  localparam int CB_BATT = 1;
  localparam int CB_MANA = 2;
  localparam int F_PH_LO = 0;
  localparam int F_PH_HI = 1;
  localparam int F_STBY_I = 2;
  localparam int F_DRV_SHORT = 3;
  localparam int F_DRV = 4;
  localparam int F_OPEN = 5;
  localparam int F_STUCK = 6;
  localparam int F_BRAKE = 7;
  localparam int F_COIL = 8;
  localparam int F_SAFETY = 9;
  localparam int F_ILK = 10;
  localparam int F_BATT_WIN = 11;
  localparam int NFAULT = 12;
  localparam int W_ACC_OFS = 0;
  localparam int W_WIRE = 1;
  localparam int W_PEDAL = 2;
  localparam int W_CTRL_HOT = 3;
  localparam int W_MOT_HOT = 4;
  localparam int W_INT_SENS = 5;
  localparam int W_MOT_SENS = 6;
  localparam int W_BUS = 7;
  localparam int W_BATT = 8;
  localparam int NWARN = 9;
  localparam int P_KEY = 0;
  localparam int P_PHL = 1;
  localparam int P_PHH = 4;
  localparam int P_DIODE = 7;
  localparam int P_IST = 8;
  localparam int P_NMC = 9;
  localparam int P_CLOSED = 10;
  localparam int P_CAPD = 11;
  localparam int P_NEB = 12;
  localparam int P_OVC = 13;
  localparam int P_OCDOK = 14;
  localparam int P_MSW = 15;
  localparam int P_SAFE = 16;
  localparam int P_BWIN = 17;
  localparam int NPIN = 18;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DIAG = 5'h02,
    ST_CLOSE = 5'h04,
    ST_RUN = 5'h08,
    ST_FAULT = 5'h10
  } tfs_state_type;
endpackage

// ==== src/tfs_supervisor.sv ====
`timescale 1ns/1ps
module tfs_supervisor #(
  parameter int DIAG_CYCLES = tfs_pkg::DIAG_CYC,
  parameter int CLOSE_CYCLES = tfs_pkg::CLOSE_CYC,
  parameter int BUS_CYCLES = tfs_pkg::BUS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic key_switch,
  input wire logic [2:0] phase_low_cmp,
  input wire logic [2:0] phase_high_cmp,
  input wire logic pot_negative_pin_sense,
  input wire logic standby_current_nz,
  input wire logic coil_drive_pin_low,
  input wire logic contactor_closed,
  input wire logic cap_discharged,
  input wire logic brake_coil_drive_pin_low,
  input wire logic coil_overcurrent,
  input wire logic ocd_selftest_ok,
  input wire logic motor_switch_open,
  input wire logic safety_in_low,
  input wire logic batt_window_ok,
  input wire logic [15:0] pot_wiper_pin_mv,
  input wire logic [7:0] ctrl_temp_c,
  input wire logic [7:0] motor_temp_c,
  input wire logic [6:0] batt_charge_pct,
  input wire logic traction_req,
  input wire logic brake_cmd,
  input wire logic bus_msg_rx,
  output logic contactor_drive,
  output logic brake_coil_driver,
  output logic cap_discharge,
  output logic motor_inhibit,
  output logic traction_enable,
  output logic [7:0] current_limit,
  output logic safety_release
);
  localparam int CW = tfs_pkg::CW;

  if (DIAG_CYCLES < 1 || DIAG_CYCLES >= 2 ** CW ||
      CLOSE_CYCLES < 1 || CLOSE_CYCLES >= 2 ** CW ||
      BUS_CYCLES < 1 || BUS_CYCLES >= 2 ** CW) begin : g_chk
    $error("tfs_supervisor: timing count out of range");
  end

  logic [tfs_pkg::NPIN-1:0] pin_raw;
  logic [tfs_pkg::NPIN-1:0] pin_m;
  logic [tfs_pkg::NPIN-1:0] pin_s;
  tfs_pkg::tfs_state_type st_q;
  tfs_pkg::tfs_state_type st_d;
  logic [tfs_pkg::NFAULT-1:0] fault_q;
  logic [tfs_pkg::NFAULT-1:0] fault_d;
  logic [tfs_pkg::NFAULT-1:0] fset;
  logic [tfs_pkg::NWARN-1:0] warn_q;
  logic [tfs_pkg::NWARN-1:0] warn_d;
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] bus_cnt_q;
  logic [7:0] brk_cnt_q;
  logic [7:0] lim_q;
  logic [7:0] lim_d;
  logic cap_pre_q;
  logic tmr_done;
  logic standby;
  logic key;
  logic safe;
  logic inhibit_d;
  logic [2:0] ctrl_q;
  logic [15:0] acc_min_q;
  logic [31:0] prange_q;
  logic [7:0] cutoff_q;
  logic [31:0] srange_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic cdrv_q;
  logic bdrv_q;
  logic capd_q;
  logic inh_q;
  logic trac_q;
  logic rel_q;

  // Pins are asynchronous to ref_clk
  assign pin_raw = {batt_window_ok, safety_in_low, motor_switch_open, ocd_selftest_ok,
                    coil_overcurrent, brake_coil_drive_pin_low, cap_discharged,
                    contactor_closed, coil_drive_pin_low, standby_current_nz,
                    pot_negative_pin_sense, phase_high_cmp, phase_low_cmp, key_switch};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_m <= '0;
      pin_s <= '0;
    end else if (ce) begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
    end
  end

  assign key = pin_s[tfs_pkg::P_KEY];
  assign safe = pin_s[tfs_pkg::P_SAFE];
  assign standby = (st_q == tfs_pkg::ST_RUN) && !trac_q;
  assign tmr_done = ((st_q == tfs_pkg::ST_DIAG) && (tmr_q >= CW'(DIAG_CYCLES - 1))) ||
                    ((st_q == tfs_pkg::ST_CLOSE) && (tmr_q >= CW'(CLOSE_CYCLES - 1)));

  always_comb begin
    st_d = st_q;
    fset = '0;
    case (st_q)
      tfs_pkg::ST_IDLE: begin
        if (key) begin
          st_d = tfs_pkg::ST_DIAG;
        end
      end
      tfs_pkg::ST_DIAG: begin
        fset[tfs_pkg::F_DRV_SHORT] = pin_s[tfs_pkg::P_NMC];
        fset[tfs_pkg::F_ILK] = safe;
        fset[tfs_pkg::F_BATT_WIN] = !pin_s[tfs_pkg::P_BWIN];
        if (tmr_done) begin
          fset[tfs_pkg::F_STUCK] = !cap_pre_q && !pin_s[tfs_pkg::P_CAPD];
          fset[tfs_pkg::F_COIL] = !pin_s[tfs_pkg::P_OCDOK];
          st_d = tfs_pkg::ST_CLOSE;
        end
      end
      tfs_pkg::ST_CLOSE: begin
        if (safe && pin_s[tfs_pkg::P_NMC] && pin_s[tfs_pkg::P_CLOSED]) begin
          st_d = tfs_pkg::ST_RUN;
        end else if (tmr_done) begin
          if (!safe) begin
            fset[tfs_pkg::F_SAFETY] = 1'b1;
          end else if (!pin_s[tfs_pkg::P_NMC]) begin
            fset[tfs_pkg::F_DRV] = 1'b1;
          end else begin
            fset[tfs_pkg::F_OPEN] = 1'b1;
          end
        end
      end
      tfs_pkg::ST_RUN: begin
        fset[tfs_pkg::F_SAFETY] = !safe;
        fset[tfs_pkg::F_DRV] = !pin_s[tfs_pkg::P_NMC];
        fset[tfs_pkg::F_OPEN] = pin_s[tfs_pkg::P_NMC] && !pin_s[tfs_pkg::P_CLOSED];
        fset[tfs_pkg::F_STBY_I] = standby && pin_s[tfs_pkg::P_IST];
      end
      default: begin
      end
    endcase
    if ((st_q == tfs_pkg::ST_DIAG) || standby) begin
      fset[tfs_pkg::F_PH_LO] = |pin_s[tfs_pkg::P_PHL +: 3];
      fset[tfs_pkg::F_PH_HI] = |pin_s[tfs_pkg::P_PHH +: 3];
    end
    fset[tfs_pkg::F_BRAKE] = (brk_cnt_q == tfs_pkg::BRK_CNT);
    if (pin_s[tfs_pkg::P_OVC]) begin
      fset[tfs_pkg::F_COIL] = 1'b1;
    end
    // Key off clears, but a fresh set in the same cycle wins
    fault_d = (key ? fault_q : '0) | fset;
    if (key && (fault_d != '0)) begin
      st_d = tfs_pkg::ST_FAULT;
    end
    if (!key) begin
      st_d = tfs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= tfs_pkg::ST_IDLE;
      fault_q <= '0;
      tmr_q <= '0;
      cap_pre_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      fault_q <= fault_d;
      tmr_q <= (st_d != st_q) ? '0 : (tmr_done ? tmr_q : tmr_q + 1'b1);
      if (st_q == tfs_pkg::ST_IDLE) begin
        cap_pre_q <= pin_s[tfs_pkg::P_CAPD];
      end
    end
  end

  // Settle window covers synchroniser delay and driver slew
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brk_cnt_q <= '0;
    end else if (ce) begin
      if (bdrv_q != pin_s[tfs_pkg::P_NEB]) begin
        brk_cnt_q <= (brk_cnt_q == tfs_pkg::BRK_CNT) ? brk_cnt_q : brk_cnt_q + 1'b1;
      end else begin
        brk_cnt_q <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_cnt_q <= '0;
    end else if (ce) begin
      if (!ctrl_q[tfs_pkg::CB_BUS] || bus_msg_rx || (st_q == tfs_pkg::ST_IDLE)) begin
        bus_cnt_q <= '0;
      end else if (bus_cnt_q < CW'(BUS_CYCLES)) begin
        bus_cnt_q <= bus_cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    warn_d = '0;
    if (standby) begin
      warn_d[tfs_pkg::W_ACC_OFS] = {1'b0, pot_wiper_pin_mv} >
                                   ({1'b0, acc_min_q} + tfs_pkg::ACC_OFS_MV);
    end else if (st_q == tfs_pkg::ST_RUN) begin
      warn_d[tfs_pkg::W_ACC_OFS] = warn_q[tfs_pkg::W_ACC_OFS];
    end
    warn_d[tfs_pkg::W_WIRE] = !pin_s[tfs_pkg::P_DIODE];
    warn_d[tfs_pkg::W_PEDAL] = (pot_wiper_pin_mv < prange_q[15:0]) ||
                               (pot_wiper_pin_mv > prange_q[31:16]);
    warn_d[tfs_pkg::W_CTRL_HOT] = ctrl_temp_c > tfs_pkg::T_DERATE_C;
    warn_d[tfs_pkg::W_MOT_HOT] = pin_s[tfs_pkg::P_MSW] ||
                                 (ctrl_q[tfs_pkg::CB_MANA] && motor_temp_c > cutoff_q);
    warn_d[tfs_pkg::W_INT_SENS] = (ctrl_temp_c < srange_q[7:0]) ||
                                  (ctrl_temp_c > srange_q[15:8]);
    warn_d[tfs_pkg::W_MOT_SENS] = ctrl_q[tfs_pkg::CB_MANA] &&
                                  ((motor_temp_c < srange_q[23:16]) ||
                                   (motor_temp_c > srange_q[31:24]));
    warn_d[tfs_pkg::W_BUS] = ctrl_q[tfs_pkg::CB_BUS] && (bus_cnt_q >= CW'(BUS_CYCLES));
    warn_d[tfs_pkg::W_BATT] = ctrl_q[tfs_pkg::CB_BATT] &&
                              (batt_charge_pct <= tfs_pkg::BATT_LOW_PCT);
  end

  assign inhibit_d = (st_d != tfs_pkg::ST_RUN) || (fault_d != '0) ||
                     warn_d[tfs_pkg::W_WIRE] || warn_d[tfs_pkg::W_PEDAL];

  // Motor derate fixed at half; a finer curve needs a sensor scale
  always_comb begin
    lim_d = tfs_pkg::LIM_FULL;
    if (ctrl_temp_c >= tfs_pkg::T_ZERO_C) begin
      lim_d = '0;
    end else if (ctrl_temp_c > tfs_pkg::T_DERATE_C) begin
      lim_d = 8'((tfs_pkg::T_ZERO_C - ctrl_temp_c) * tfs_pkg::LIM_STEP);
    end
    if ((warn_d[tfs_pkg::W_MOT_HOT] || warn_d[tfs_pkg::W_INT_SENS] ||
         warn_d[tfs_pkg::W_MOT_SENS] || warn_d[tfs_pkg::W_BATT]) &&
        (lim_d > tfs_pkg::LIM_HALF)) begin
      lim_d = tfs_pkg::LIM_HALF;
    end
    if (inhibit_d) begin
      lim_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warn_q <= '0;
      lim_q <= '0;
      cdrv_q <= 1'b0;
      bdrv_q <= 1'b0;
      capd_q <= 1'b0;
      inh_q <= 1'b1;
      trac_q <= 1'b0;
      rel_q <= 1'b0;
    end else if (ce) begin
      warn_q <= warn_d;
      lim_q <= lim_d;
      cdrv_q <= ((st_d == tfs_pkg::ST_CLOSE) || (st_d == tfs_pkg::ST_RUN)) &&
                (fault_d == '0) && safe;
      bdrv_q <= brake_cmd && (st_d == tfs_pkg::ST_RUN) &&
                (fault_d == '0) && safe;
      capd_q <= (st_d == tfs_pkg::ST_DIAG) && !cap_pre_q;
      inh_q <= inhibit_d;
      trac_q <= traction_req && !inhibit_d && !warn_d[tfs_pkg::W_ACC_OFS];
      rel_q <= (st_d == tfs_pkg::ST_CLOSE) || (st_d == tfs_pkg::ST_RUN);
    end
  end

  assign contactor_drive = cdrv_q;
  assign brake_coil_driver = bdrv_q;
  assign cap_discharge = capd_q;
  assign motor_inhibit = inh_q;
  assign traction_enable = trac_q;
  assign current_limit = lim_q;
  assign safety_release = rel_q;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] stb);
    for (int b = 0; b < 4; b++) begin
      wmerge[8 * b +: 8] = stb[b] ? nw[8 * b +: 8] : old[8 * b +: 8];
    end
  endfunction

  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign wr_ok = (awaddr_q[7:2] <= tfs_pkg::A_SRANGE[7:2]);

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      tfs_pkg::A_CTRL[7:2]: rd_mux = 32'(ctrl_q);
      tfs_pkg::A_ACC_MIN[7:2]: rd_mux = 32'(acc_min_q);
      tfs_pkg::A_PRANGE[7:2]: rd_mux = prange_q;
      tfs_pkg::A_CUTOFF[7:2]: rd_mux = 32'(cutoff_q);
      tfs_pkg::A_SRANGE[7:2]: rd_mux = srange_q;
      tfs_pkg::A_FAULT[7:2]: rd_mux = 32'(fault_q);
      tfs_pkg::A_WARN[7:2]: rd_mux = 32'(warn_q);
      tfs_pkg::A_STAT[7:2]: rd_mux = 32'({st_q, lim_q});
      default: begin
        rd_mux = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // One write and one read in flight; ready drops until the response is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= tfs_pkg::RESP_OK;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end else if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? tfs_pkg::RESP_OK : tfs_pkg::RESP_ERR;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= tfs_pkg::CTRL_RST;
      acc_min_q <= tfs_pkg::ACC_MIN_RST;
      prange_q <= tfs_pkg::PRANGE_RST;
      cutoff_q <= tfs_pkg::CUTOFF_RST;
      srange_q <= tfs_pkg::SRANGE_RST;
    end else if (ce && wr_go) begin
      case (awaddr_q[7:2])
        tfs_pkg::A_CTRL[7:2]: ctrl_q <= 3'(wmerge(32'(ctrl_q), wdata_q, wstrb_q));
        tfs_pkg::A_ACC_MIN[7:2]: acc_min_q <= 16'(wmerge(32'(acc_min_q), wdata_q, wstrb_q));
        tfs_pkg::A_PRANGE[7:2]: prange_q <= wmerge(prange_q, wdata_q, wstrb_q);
        tfs_pkg::A_CUTOFF[7:2]: cutoff_q <= 8'(wmerge(32'(cutoff_q), wdata_q, wstrb_q));
        tfs_pkg::A_SRANGE[7:2]: srange_q <= wmerge(srange_q, wdata_q, wstrb_q);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= tfs_pkg::RESP_OK;
      rdata_q <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? tfs_pkg::RESP_OK : tfs_pkg::RESP_ERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  AST_PHASE_LOW:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && ((st_q == tfs_pkg::ST_DIAG) || standby) && |pin_s[tfs_pkg::P_PHL +: 3])
      |=> fault_q[tfs_pkg::F_PH_LO])
    else $error("phase low fault not latched");
  AST_ACC_OFS:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && standby && ({1'b0, pot_wiper_pin_mv} > ({1'b0, acc_min_q} + tfs_pkg::ACC_OFS_MV)))
      |=> warn_q[tfs_pkg::W_ACC_OFS])
    else $error("accelerator offset alarm missing");
  AST_OFS_BLOCK:
    assert property (@(posedge ref_clk) disable iff (rst)
      warn_q[tfs_pkg::W_ACC_OFS] |-> !trac_q)
    else $error("traction enabled under offset alarm");
  AST_WIRE:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !pin_s[tfs_pkg::P_DIODE]) |=> (warn_q[tfs_pkg::W_WIRE] && inh_q && !trac_q))
    else $error("pedal wire alarm not blocking");
  AST_PEDAL:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && (pot_wiper_pin_mv > prange_q[31:16])) |=> (warn_q[tfs_pkg::W_PEDAL] && inh_q))
    else $error("pedal failure not blocking");
  AST_HARD_STOP:
    assert property (@(posedge ref_clk) disable iff (rst)
      (fault_q != '0) |-> (!cdrv_q && !bdrv_q && inh_q && (lim_q == '0)))
    else $error("hard fault left contactor or drive active");
  AST_DRV_SHORT:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && (st_q == tfs_pkg::ST_DIAG) && pin_s[tfs_pkg::P_NMC])
      |=> (fault_q[tfs_pkg::F_DRV_SHORT] && !cdrv_q))
    else $error("shorted driver not flagged");
  AST_TEMP_ZERO:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && (ctrl_temp_c >= tfs_pkg::T_ZERO_C)) |=> (lim_q == '0))
    else $error("current not zero at top temperature");
  AST_SAFETY:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && key && (st_q == tfs_pkg::ST_RUN) && !safe)
      |=> (fault_q[tfs_pkg::F_SAFETY] && !cdrv_q && !bdrv_q))
    else $error("open interlock did not stop drivers");
  AST_BATT_LOW:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && ctrl_q[tfs_pkg::CB_BATT] && (batt_charge_pct <= tfs_pkg::BATT_LOW_PCT))
      |=> (warn_q[tfs_pkg::W_BATT] && (lim_q <= tfs_pkg::LIM_HALF)))
    else $error("low battery did not halve current");
  AST_LATCH:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ce && key) |=> ((fault_q & $past(fault_q)) == $past(fault_q)))
    else $error("hard fault cleared with key on");
endmodule

// ==== tb/tfs_power_stage.sv ====
`timescale 1ns/1ps
module tfs_power_stage (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic contactor_drive,
  input wire logic brake_coil_driver,
  input wire logic cap_discharge,
  input wire logic safety_release,
  output logic coil_drive_pin_low,
  output logic contactor_closed,
  output logic cap_discharged,
  output logic brake_coil_drive_pin_low,
  output logic safety_in_low
);
  logic [1:0] close_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coil_drive_pin_low <= 1'b0;
      close_q <= 2'h0;
      contactor_closed <= 1'b0;
      cap_discharged <= 1'b0;
      brake_coil_drive_pin_low <= 1'b0;
      safety_in_low <= 1'b0;
    end else begin
      coil_drive_pin_low <= contactor_drive;
      close_q <= {close_q[0], contactor_drive};
      // Armature is slower than the coil pin
      contactor_closed <= close_q[1];
      brake_coil_drive_pin_low <= brake_coil_driver;
      if (cap_discharge) begin
        cap_discharged <= 1'b1;
      end else if (contactor_closed) begin
        cap_discharged <= 1'b0;
      end
      safety_in_low <= safety_release;
    end
  end
endmodule

// ==== tb/traction_fault_supervisor_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module traction_fault_supervisor_test;
  logic ref_clk = 0, rst = 1, ce = 1, key_switch = 0, traction_req = 0, brake_cmd = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, bus_msg_rx = 0, motor_switch_open = 0, pot_negative_pin_sense = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ctrl_temp_c = 25, motor_temp_c = 25;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, xs_q = 32'd19135;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] phase_low_cmp = 0, phase_high_cmp = 0;
  logic [15:0] pot_wiper_pin_mv = 16'd1000;
  logic [6:0] batt_charge_pct = 7'd80;
  logic standby_current_nz = 0, coil_overcurrent = 0, bus_on = 1;
  logic coil_drive_pin_low, contactor_closed, cap_discharged, brake_coil_drive_pin_low;
  logic safety_in_low, contactor_drive, brake_coil_driver, cap_discharge, motor_inhibit;
  logic traction_enable, safety_release;
  logic [7:0] current_limit;
  int err_total = 0, checks_done = 0, cyc = 0, t;
  tfs_supervisor #(.DIAG_CYCLES(16), .CLOSE_CYCLES(32), .BUS_CYCLES(64)) tfs_supervisor_inst (
    .ref_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .key_switch, .phase_low_cmp, .phase_high_cmp, .pot_negative_pin_sense,
    .standby_current_nz, .coil_drive_pin_low, .contactor_closed, .cap_discharged,
    .brake_coil_drive_pin_low, .coil_overcurrent, .ocd_selftest_ok(1'b1),
    .motor_switch_open, .safety_in_low, .batt_window_ok(1'b1), .pot_wiper_pin_mv,
    .ctrl_temp_c, .motor_temp_c, .batt_charge_pct, .traction_req, .brake_cmd, .bus_msg_rx,
    .contactor_drive, .brake_coil_driver, .cap_discharge, .motor_inhibit, .traction_enable,
    .current_limit, .safety_release);
  tfs_power_stage tfs_power_stage_inst (.ref_clk, .rst, .contactor_drive, .brake_coil_driver,
    .cap_discharge, .safety_release, .coil_drive_pin_low, .contactor_closed, .cap_discharged,
    .brake_coil_drive_pin_low, .safety_in_low);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs();
    xs_q = xs_q ^ (xs_q << 13);
    xs_q = xs_q ^ (xs_q >> 17);
    xs_q = xs_q ^ (xs_q << 5);
    return xs_q;
  endfunction
  function automatic int exp_lim(int tc, int low);
    int l;
    l = tc >= 100 ? 0 : (tc > 75 ? (100 - tc) * 10 : 250);
    if (low != 0 && l > 125) l = 125;
    return l;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, er)
    `CHK(s_axi_rdata, ed)
  endtask
  task automatic wait_run();
    while (motor_inhibit !== 1'b0) @(posedge ref_clk);
    `CHK(contactor_drive, 1'b1)
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    // Random traffic never leaves a long gap; silence comes only from bus_on
    bus_msg_rx <= bus_on & 1'(xs() % 2);
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    axr(tfs_pkg::A_STAT, {19'h0, tfs_pkg::ST_IDLE, 8'h00}, tfs_pkg::RESP_OK);
    axr(tfs_pkg::A_ACC_MIN, 32'h1f4, tfs_pkg::RESP_OK);
    axw(tfs_pkg::A_FAULT, 32'h1, tfs_pkg::RESP_ERR);
    axr(8'h20, 32'h0, tfs_pkg::RESP_ERR);
    axw(tfs_pkg::A_CTRL, 32'h2, tfs_pkg::RESP_OK);
    $display("register test done");
    key_switch <= 1'b1;
    wait_run();
    traction_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(traction_enable, 1'b1)
    for (int i = 0; i < 8; i++) begin
      t = i == 0 ? 75 : (i == 1 ? 100 : 76 + xs() % 24);
      ctrl_temp_c <= 8'(t);
      batt_charge_pct <= (i % 2) ? 7'd10 : 7'd11;
      repeat (4) @(posedge ref_clk);
      `CHK(current_limit, 8'(exp_lim(t, i % 2)))
    end
    ctrl_temp_c <= 8'd25;
    batt_charge_pct <= 7'd80;
    traction_req <= 1'b0;
    $display("derate test done");
    repeat (4) @(posedge ref_clk);
    pot_wiper_pin_mv <= 16'd1501;
    repeat (4) @(posedge ref_clk);
    traction_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(traction_enable, 1'b0)
    axr(tfs_pkg::A_WARN, 32'h1, tfs_pkg::RESP_OK);
    traction_req <= 1'b0;
    pot_wiper_pin_mv <= 16'd1000;
    $display("offset test done");
    pot_negative_pin_sense <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(motor_inhibit, 1'b1)
    pot_negative_pin_sense <= 1'b1;
    pot_wiper_pin_mv <= 16'd4501;
    repeat (4) @(posedge ref_clk);
    `CHK(motor_inhibit, 1'b1)
    pot_wiper_pin_mv <= 16'd1000;
    repeat (4) @(posedge ref_clk);
    `CHK(motor_inhibit, 1'b0)
    $display("pedal test done");
    phase_low_cmp <= 3'h2;
    repeat (6) @(posedge ref_clk);
    `CHK({motor_inhibit, contactor_drive}, 2'b10)
    phase_low_cmp <= 3'h0;
    repeat (6) @(posedge ref_clk);
    axr(tfs_pkg::A_FAULT, 32'h1, tfs_pkg::RESP_OK);
    key_switch <= 1'b0;
    repeat (6) @(posedge ref_clk);
    key_switch <= 1'b1;
    wait_run();
    axr(tfs_pkg::A_FAULT, 32'h0, tfs_pkg::RESP_OK);
    $display("fault test done");
    ce <= 1'b0;
    traction_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK(traction_enable, 1'b0)
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(traction_enable, 1'b1)
    traction_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    standby_current_nz <= 1'b1;
    repeat (6) @(posedge ref_clk);
    axr(tfs_pkg::A_FAULT, 32'h4, tfs_pkg::RESP_OK);
    $display("standby test done");
    standby_current_nz <= 1'b0;
    key_switch <= 1'b0;
    repeat (6) @(posedge ref_clk);
    key_switch <= 1'b1;
    wait_run();
    coil_overcurrent <= 1'b1;
    @(posedge ref_clk);
    coil_overcurrent <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK({motor_inhibit, contactor_drive}, 2'b10)
    axr(tfs_pkg::A_FAULT, 32'h100, tfs_pkg::RESP_OK);
    axw(tfs_pkg::A_CTRL, 32'h3, tfs_pkg::RESP_OK);
    bus_on <= 1'b0;
    repeat (70) @(posedge ref_clk);
    axr(tfs_pkg::A_WARN, 32'h80, tfs_pkg::RESP_OK);
    $display("coil and bus test done");
    test_done();
  end
endmodule
